// [src/interrupt_service_poll_mask.sv]
`timescale 1ns/1ps
`default_nettype none

module interrupt_service_poll_mask (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode and sources, same clock domain
    input wire logic slave_mode,
    input wire logic [15:0] req_bits,
    input wire logic [47:0] source_prio,
    input wire logic cpu_accept,
    // To request and control logic
    output logic [15:0] req_clear,
    output logic [15:0] mask_bits,
    output logic [15:0] service_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [15:0] service_q, service_d;   // In-service flags
    logic [15:0] mask_q, mask_d;         // Per-source masks
    logic [2:0] thresh_q, thresh_d;      // Priority threshold
    logic [31:0] prdata_q, prdata_d;     // Read data
    logic pready_q, pslverr_q;           // Bus answer
    logic [15:0] clr_q, clr_d;           // Request clear pulse
    logic mode_q;                        // Mode seen last cycle

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire logic access = psel & penable;
    wire logic done = access & pready_q;      // Edge that completes a transfer
    wire logic wr_done = done & pwrite;
    wire logic rd_done = done & ~pwrite;
    wire logic hit_service = paddr == isp_pkg::OFS_SERVICE;
    wire logic hit_thresh = paddr == isp_pkg::OFS_THRESHOLD;
    wire logic hit_mask = paddr == isp_pkg::OFS_MASK;
    wire logic hit_peek = paddr == isp_pkg::OFS_PEEK;
    wire logic hit_take = paddr == isp_pkg::OFS_TAKE;
    wire logic hit_eos = paddr == isp_pkg::OFS_EOS;
    wire logic hit_req = paddr == isp_pkg::OFS_REQUEST;
    wire logic hit_any = hit_service | hit_thresh | hit_mask | hit_peek | hit_take | hit_eos | hit_req;
    wire logic [15:0] src_valid = slave_mode ? isp_pkg::SRC_SLAVE : isp_pkg::SRC_MASTER;

    ////////////////////////////////////////////////////////////////////////////
    // Highest-priority pending search

    isp_pkg::pick_s pend;   // Best eligible request
    isp_pkg::pick_s svc;    // Best in-service flag

    // Lowest priority code wins, ties go to the lower bit
    always_comb begin
        pend = '0;
        svc = '0;
        for (int i = 0; i < isp_pkg::NSRC; i++) begin
            // Eligible: requesting, unmasked, within threshold
            if (src_valid[i] && req_bits[i] && !mask_q[i] &&
                source_prio[i*isp_pkg::PRIO_W +: isp_pkg::PRIO_W] <= thresh_q) begin
                if (!pend.valid || source_prio[i*isp_pkg::PRIO_W +: isp_pkg::PRIO_W] < pend.prio) begin
                    pend.valid = 1'b1;
                    pend.idx = i[3:0];
                    pend.prio = source_prio[i*isp_pkg::PRIO_W +: isp_pkg::PRIO_W];
                end
            end
            // Highest in-service source for nonspecific end of service
            if (service_q[i]) begin
                if (!svc.valid || source_prio[i*isp_pkg::PRIO_W +: isp_pkg::PRIO_W] < svc.prio) begin
                    svc.valid = 1'b1;
                    svc.idx = i[3:0];
                    svc.prio = source_prio[i*isp_pkg::PRIO_W +: isp_pkg::PRIO_W];
                end
            end
        end
    end

    // Type reported for the winner: slave uses the level code, i.e. the bit
    wire logic [4:0] master_type = isp_pkg::MASTER_TYPES[pend.idx*isp_pkg::TYPE_W +: isp_pkg::TYPE_W];
    wire logic [4:0] pend_type = slave_mode ? {1'b0, pend.idx} : master_type;
    // Same word for peek and take views
    wire logic [15:0] poll_word = {pend.valid, 10'h000, pend.valid ? pend_type : 5'h00};

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge and end of service

    // Processor acceptance or a take read both acknowledge the winner
    wire logic take_rd = rd_done & hit_take;
    wire logic ack = (cpu_accept | take_rd) & pend.valid;
    wire logic [15:0] ack_vec = ack ? (16'h0001 << pend.idx) : 16'h0000;
    wire logic eos_wr = wr_done & hit_eos;

    logic [15:0] eos_vec;   // In-service bits to clear

    // Decode which in-service flag the end-of-service write releases
    always_comb begin
        eos_vec = 16'h0000;
        if (eos_wr) begin
            if (slave_mode) begin
                eos_vec = 16'h0001 << pwdata[isp_pkg::LEVEL_W-1:0];
            end else if (pwdata[isp_pkg::NONSPECIFIC_FLAG_BIT]) begin
                eos_vec = svc.valid ? (16'h0001 << svc.idx) : 16'h0000;
            end else begin
                for (int i = 0; i < isp_pkg::NSRC; i++) begin
                    // Specific: match the written type
                    if (isp_pkg::MASTER_TYPES[i*isp_pkg::TYPE_W +: isp_pkg::TYPE_W] == pwdata[4:0]) begin
                        eos_vec[i] = 1'b1;
                    end
                end
            end
        end
    end

    // A take in the same cycle as its clear wins; unused bits held at zero
    assign service_d = ((service_q & ~eos_vec) | ack_vec) & src_valid;
    assign clr_d = ack_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    // Mode flip reloads the mask defaults for the new layout
    assign mask_d = (slave_mode != mode_q) ? (slave_mode ? isp_pkg::MASK_SLAVE_RST : isp_pkg::MASK_MASTER_RST) :
                    (wr_done && hit_mask) ? (pwdata[15:0] & src_valid) : mask_q;
    assign thresh_d = (wr_done && hit_thresh) ? pwdata[2:0] : thresh_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    // Views are masked by mode so reserved bits read zero
    assign prdata_d = hit_service ? {16'h0000, service_q & src_valid} :
                      hit_thresh ? {29'h0, thresh_q} :
                      hit_mask ? {16'h0000, mask_q & src_valid} :
                      hit_req ? {16'h0000, req_bits & src_valid} :
                      (hit_peek || hit_take) ? {16'h0000, poll_word} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Flops

    // Bus answers one cycle into the access phase; data latched alongside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit_any;
            prdata_q <= (access && !pready_q && !pwrite) ? prdata_d : 32'h0;
        end
    end

    // Controller state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service_q <= 16'h0000;
            mask_q <= isp_pkg::MASK_MASTER_RST;
            thresh_q <= isp_pkg::THRESHOLD_RST;
            clr_q <= 16'h0000;
            mode_q <= 1'b0;
        end else begin
            service_q <= service_d;
            mask_q <= mask_d;
            thresh_q <= thresh_d;
            clr_q <= clr_d;
            mode_q <= slave_mode;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign req_clear = clr_q;
    assign mask_bits = mask_q;
    assign service_flags = service_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_take_sets_service: assert property (@(posedge pclk) disable iff (!presetn)
        ack |=> service_q[$past(pend.idx)])
        else $error("acknowledged source not marked in service");

    a_service_clear_cause: assert property (@(posedge pclk) disable iff (!presetn)
        (!slave_mode && $past(!slave_mode) && $fell(service_q[0])) |-> $past(eos_wr))
        else $error("in-service flag cleared without end-of-service write");

    a_slave_level_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (eos_wr && slave_mode && !ack && pwdata[2:0] == 3'h4) |=> !service_q[4])
        else $error("slave level code did not clear its flag");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (slave_mode && $past(slave_mode)) |-> (service_q[15:6] == 10'h000))
        else $error("reserved in-service bits set in slave mode");

    a_poll_valid_type: assert property (@(posedge pclk) disable iff (!presetn)
        !pend.valid |-> (poll_word == 16'h0000))
        else $error("type shown with nothing pending");

    a_threshold_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pend.valid |-> (pend.prio <= thresh_q && !mask_q[pend.idx] && req_bits[pend.idx]))
        else $error("ineligible source selected");

    a_peek_harmless: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && hit_peek && !cpu_accept) |=> (clr_q == 16'h0000))
        else $error("peek read acknowledged a request");

    a_take_clears_req: assert property (@(posedge pclk) disable iff (!presetn)
        (take_rd && pend.valid) |=> $onehot(clr_q) ##1 (clr_q == 16'h0000 || $past(ack)))
        else $error("take read did not pulse one request clear");

    a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |=> pready_q)
        else $error("slave did not answer in the second access cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on bus answer, acknowledge, end of service, reserved bits and register writes

    // Ready is a single-cycle answer, never held over
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q)
        else $error("ready held for more than one cycle");

    // An error is only ever reported together with ready
    a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr_q |-> pready_q)
        else $error("error shown without ready");

    // Read data is zero outside the answer cycle
    a_read_data_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready_q |-> (prdata_q == 32'h0))
        else $error("read data not zero outside answer cycle");

    // The clear pulse names at most one source
    a_clear_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(clr_q))
        else $error("request clear names more than one source");

    // The clear pulse follows the acknowledge by one cycle
    a_clear_follows_ack: assert property (@(posedge pclk) disable iff (!presetn)
        ack |=> (clr_q == $past(ack_vec)))
        else $error("request clear does not follow acknowledge");

    // No in-service flag rises without an acknowledge on the edge before
    a_service_set_cause: assert property (@(posedge pclk) disable iff (!presetn)
        ((service_q & ~$past(service_q)) != 16'h0000) |-> $past(ack))
        else $error("in-service flag set without acknowledge");

    // A specific end of service releases the flag of the written type
    a_specific_eos_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (eos_wr && !slave_mode && !pwdata[isp_pkg::NONSPECIFIC_FLAG_BIT] && !ack) |=>
            ((service_q & $past(eos_vec)) == 16'h0000))
        else $error("specific end of service left its flag set");

    // A nonspecific end of service releases the highest flag in service
    a_nonspec_eos_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (eos_wr && !slave_mode && pwdata[isp_pkg::NONSPECIFIC_FLAG_BIT] && svc.valid && !ack) |=>
            !service_q[$past(svc.idx)])
        else $error("nonspecific end of service left highest flag set");

    // Master layout keeps its reserved in-service bits clear
    a_master_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (!slave_mode && $past(!slave_mode)) |-> (!service_q[1] && service_q[15:11] == 5'h00))
        else $error("reserved in-service bits set in master mode");

    // Masks outside the layout of the settled mode stay clear
    a_mask_layout: assert property (@(posedge pclk) disable iff (!presetn)
        (slave_mode == mode_q) |-> ((mask_q & ~src_valid) == 16'h0000))
        else $error("mask bit set outside the mode layout");

    // A threshold write lands on the completing edge
    a_threshold_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && hit_thresh) |=> (thresh_q == $past(pwdata[2:0])))
        else $error("threshold write did not land");

endmodule : interrupt_service_poll_mask

`default_nettype wire

// [include/isp_pkg.sv]
package isp_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_SERVICE = 8'h00;
    localparam logic [7:0] OFS_THRESHOLD = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_PEEK = 8'h0c;
    localparam logic [7:0] OFS_TAKE = 8'h10;
    localparam logic [7:0] OFS_EOS = 8'h14;
    localparam logic [7:0] OFS_REQUEST = 8'h18;

    // Reset values
    localparam logic [2:0] THRESHOLD_RST = 3'h7;
    localparam logic [15:0] MASK_MASTER_RST = 16'h07fd;
    localparam logic [15:0] MASK_SLAVE_RST = 16'h003d;

    // Implemented source bits per mode
    localparam logic [15:0] SRC_MASTER = 16'h07fd;
    localparam logic [15:0] SRC_SLAVE = 16'h003d;

    // Field positions
    localparam int PEND_VALID_BIT = 15;
    localparam int NONSPECIFIC_FLAG_BIT = 15;
    localparam int TYPE_W = 5;
    localparam int LEVEL_W = 3;
    localparam int PRIO_W = 3;
    localparam int NSRC = 16;

    // Master type per bit position, 5 bits each, bit 0 in the low field
    localparam logic [79:0] MASTER_TYPES = {
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00,   // Bits 15..11 unused
        5'h14, 5'h11,                        // Serial zero, serial one
        5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c,   // Pins four..zero
        5'h0b, 5'h0a, 5'h00, 5'h08           // Dma one, dma zero, none, timer
    };

    // Result of a priority search
    typedef struct packed {
        logic valid;
        logic [3:0] idx;
        logic [2:0] prio;
    } pick_s;

endpackage : isp_pkg

// [verif/source_model.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Request sources: raised by the bench, dropped on acknowledge
module source_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raise pulses and acknowledge pulses
    input wire logic [15:0] set_bits,
    input wire logic [15:0] req_clear,
    // Live request levels
    output logic [15:0] req_bits
);
    logic [15:0] req_q; // Held requests
    assign req_bits = req_q;
    // A request stays up until its own acknowledge arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 16'h0000;
        end else begin
            req_q <= (req_q & ~req_clear) | set_bits;
        end
    end
endmodule : source_model
`default_nettype wire

// [verif/interrupt_service_poll_mask_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module interrupt_service_poll_mask_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slave_mode, cpu_accept, err, md;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] req_bits, set_bits, req_clear, mask_bits, service_flags, m_req, m_mask, m_isv, src, d;
    logic [47:0] source_prio;
    logic [2:0] m_thr; // Model threshold
    logic [2:0] m_prio [16]; // Model source priorities
    int n_fail = 0;
    int checks_done = 0;
    int win; // Model winner, -1 when idle
    interrupt_service_poll_mask interrupt_service_poll_mask_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .slave_mode(slave_mode),
        .req_bits(req_bits), .source_prio(source_prio), .cpu_accept(cpu_accept),
        .req_clear(req_clear), .mask_bits(mask_bits), .service_flags(service_flags));
    source_model source_model_inst (.pclk(pclk), .presetn(presetn), .set_bits(set_bits),
        .req_clear(req_clear), .req_bits(req_bits));
    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard, far above the expected run
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    // Lowest priority value wins, ties to lowest position
    function int pick(input logic [15:0] v);
        int b;
        b = -1;
        for (int i = 0; i < 16; i++) if (v[i] && (b < 0 || m_prio[i] < m_prio[b])) b = i;
        return b;
    endfunction : pick
    // Expected poll word; also records the winner
    function logic [31:0] poll();
        logic [15:0] v;
        for (int i = 0; i < 16; i++) v[i] = m_req[i] & ~m_mask[i] & src[i] & (m_prio[i] <= m_thr);
        win = pick(v);
        if (win < 0) return 32'h0;
        return {16'h0, 1'b1, 10'h0, md ? 5'(win) : isp_pkg::MASTER_TYPES[5*win+:5]};
    endfunction : poll
    // One APB transfer; holds everything until pready is seen or 20 cycles pass
    task apb(input logic w, input logic [7:0] a, input logic [15:0] v);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0, v};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // Peek, then acknowledge by take read or by processor accept
    task ack(input int take);
        logic [31:0] e;
        e = poll();
        apb(0, isp_pkg::OFS_PEEK, 0); chk(rd, e);
        if (take) begin
            apb(0, isp_pkg::OFS_TAKE, 0); chk(rd, e);
        end else begin
            @(posedge pclk) cpu_accept <= 1;
            @(posedge pclk) cpu_accept <= 0;
        end
        if (win >= 0) begin m_isv[win] = 1; m_req[win] = 0; end
        repeat (2) @(posedge pclk);
        chk({16'h0, service_flags}, {16'h0, m_isv});
    endtask : ack
    // End of service: slave by level, master by type or nonspecific
    task eos(input int ns);
        int b;
        b = pick(m_isv);
        d = md ? 16'(b) : ns ? 16'h8000 : {11'h0, isp_pkg::MASTER_TYPES[5*b+:5]};
        apb(1, isp_pkg::OFS_EOS, d);
        m_isv[b] = 0;
        apb(0, isp_pkg::OFS_SERVICE, 0); chk(rd, {16'h0, m_isv});
    endtask : eos
    ////////////////////////////////////////////////////////////
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        slave_mode = 0; cpu_accept = 0; set_bits = 16'h0; source_prio = 48'h0;
        m_isv = 0; m_req = 0;
        void'($urandom(3673));
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, isp_pkg::OFS_THRESHOLD, 0); chk(rd, 32'h7);
        apb(0, 8'h1c, 0); chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        for (int m = 0; m < 2; m++) begin
            md = m[0];
            slave_mode <= md;
            src = md ? isp_pkg::SRC_SLAVE : isp_pkg::SRC_MASTER;
            m_mask = md ? isp_pkg::MASK_SLAVE_RST : isp_pkg::MASK_MASTER_RST;
            @(posedge pclk);
            apb(0, isp_pkg::OFS_MASK, 0); chk(rd, {16'h0, m_mask});
            chk({16'h0, mask_bits}, {16'h0, m_mask});
            repeat (3) begin
                d = 16'($urandom);
                apb(1, isp_pkg::OFS_MASK, d);
                m_mask = d & src;
                apb(0, isp_pkg::OFS_MASK, 0); chk(rd, {16'h0, m_mask});
                m_thr = 3'($urandom);
                apb(1, isp_pkg::OFS_THRESHOLD, 16'(m_thr));
                for (int i = 0; i < 16; i++) begin
                    m_prio[i] = 3'($urandom);
                    source_prio[3*i+:3] <= m_prio[i];
                end
                d = 16'($urandom) & src;
                m_req |= d;
                set_bits <= d;
                @(posedge pclk) set_bits <= 16'h0;
                @(posedge pclk);
                apb(0, isp_pkg::OFS_REQUEST, 0); chk(rd, {16'h0, m_req & src});
                for (int k = 0; k < 8; k++) ack(k % 2);
                while (m_isv != 0) eos($urandom % 2);
            end
        end
        conclude();
    end
endmodule : interrupt_service_poll_mask_tb
`default_nettype wire
